// ===== rtl/aod_pkg.sv
package aod_pkg;
	// channel count and record geometry
	localparam int NUM_CH = 4;
	localparam int DIAG_FULL_LEN = 20;
	localparam int DIAG_SHORT_LEN = 4;
	localparam logic [7:0] NUM_CH_BYTE = 8'h04;
	localparam logic [7:0] DIAG_BITS_BYTE = 8'h08;
	localparam logic [7:0] MODULE_INFO_RST = 8'h15;
	localparam logic [7:0] CHANNEL_KIND_RST = 8'h73;

	// record numbers on the parameter and diagnostic ports
	localparam logic [7:0] REC_PRM_BASE = 8'h00;
	localparam logic [7:0] REC_FN_CH0 = 8'h80;
	localparam logic [7:0] REC_DIAG_SHORT = 8'h00;
	localparam logic [7:0] REC_DIAG_FULL = 8'h01;
	localparam logic [4:0] IDX_PRM_WIRE_BREAK = 5'h01;

	// reset values of the parameter record
	localparam logic [7:0] WIRE_BREAK_EN_RST = 8'h00;
	localparam logic [7:0] FUNC_SEL_RST = 8'h31;
	localparam logic [3:0] WIRE_BREAK_EN_MASK = 4'hf;

	// function numbers
	localparam logic [7:0] FN_OFF = 8'hff;
	localparam logic [7:0] FN_0_20_NOM27648 = 8'h31;
	localparam logic [7:0] FN_0_20_NOM16384 = 8'h41;
	localparam logic [7:0] FN_4_20_NOM27648 = 8'h30;
	localparam logic [7:0] FN_4_20_NOM16384 = 8'h40;

	// code limits per format
	localparam logic signed [15:0] CODE_ZERO = 16'sh0000;
	localparam logic signed [15:0] CODE_MAX_27648 = 16'sh7eff;
	localparam logic signed [15:0] CODE_MAX_16384 = 16'sh5000;
	localparam logic signed [15:0] CODE_MIN_4MA_27648 = 16'she500;
	localparam logic signed [15:0] CODE_MIN_4MA_16384 = 16'shf000;

	// scale factors: microamps per code step, times 2^16
	localparam logic signed [17:0] K_20MA_27648 = 18'sh0b92f;
	localparam logic signed [17:0] K_20MA_16384 = 18'sh13880;
	localparam logic signed [17:0] K_16MA_27648 = 18'sh09426;
	localparam logic signed [17:0] K_16MA_16384 = 18'sh0fa00;
	localparam logic signed [15:0] OFFSET_4MA_UA = 16'sh0fa0;
	localparam logic signed [15:0] OFFSET_0MA_UA = 16'sh0000;

	// summary and other diagnostic byte fields
	localparam int SUM_MODULE_FAIL = 0;
	localparam int SUM_INTERNAL = 1;
	localparam int SUM_EXTERNAL = 2;
	localparam int SUM_CHANNEL = 3;
	localparam int SUM_AUX_MISSING = 4;
	localparam int SUM_PARAM = 7;
	localparam int MODINFO_CHAN_PRESENT = 4;
	localparam int INT_DIAG_OVERFLOW = 3;
	localparam int INT_COMM_ERROR = 4;
	localparam int CHANNEL_GROUP_ERRORS_PARAM = 0;
	localparam int CHANNEL_GROUP_ERRORS_WIRE_BREAK = 4;

	// microsecond tick
	localparam int CLK_MHZ = 250;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
endpackage : aod_pkg

// ===== rtl/aod_scaler.sv
`timescale 1ns/1ps
module aod_scaler
	import aod_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] func_i,
	input wire logic [15:0] code_i,
	output logic [14:0] current_o,
	output logic active_o
);
	logic signed [15:0] code_s; // code as a signed value
	logic signed [15:0] lo_lim; // lowest accepted code
	logic signed [15:0] hi_lim; // highest accepted code
	logic signed [17:0] scale_k; // uA per step, fixed point
	logic signed [15:0] offset_ua; // 4 mA lift for live zero
	logic known_fn; // function number is a scaling format
	logic signed [15:0] code_c; // clamped code
	logic signed [33:0] prod; // scaled product
	logic signed [15:0] sum_ua; // target before final clamp
	logic [14:0] current_d;

	assign code_s = code_i;
	assign known_fn = (func_i == FN_0_20_NOM27648) || (func_i == FN_0_20_NOM16384)
		|| (func_i == FN_4_20_NOM27648) || (func_i == FN_4_20_NOM16384);
	// format selection
	assign lo_lim = (func_i == FN_4_20_NOM27648) ? CODE_MIN_4MA_27648 :
		(func_i == FN_4_20_NOM16384) ? CODE_MIN_4MA_16384 : CODE_ZERO; // R03 R04 R05 R06
	assign hi_lim = ((func_i == FN_0_20_NOM27648) || (func_i == FN_4_20_NOM27648))
		? CODE_MAX_27648 : CODE_MAX_16384; // R03 R04 R05 R06
	assign scale_k = (func_i == FN_0_20_NOM27648) ? K_20MA_27648 : // R03
		(func_i == FN_0_20_NOM16384) ? K_20MA_16384 : // R04
		(func_i == FN_4_20_NOM27648) ? K_16MA_27648 : K_16MA_16384; // R05 R06
	assign offset_ua = ((func_i == FN_4_20_NOM27648) || (func_i == FN_4_20_NOM16384))
		? OFFSET_4MA_UA : OFFSET_0MA_UA; // R05 R06
	// clamp below and above; the lowest accepted code ends at 0 mA
	assign code_c = (code_s < lo_lim) ? lo_lim : (code_s > hi_lim) ? hi_lim : code_s;
	assign prod = code_c * scale_k;
	// floor may land one step under zero at the lowest code; the sign test clamps it
	assign sum_ua = prod[31:16] + offset_ua;
	assign current_d = (!known_fn || sum_ua[15]) ? 15'h0000 : sum_ua[14:0];

	// registered target; unknown or off functions drive nothing
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			current_o <= 15'h0000;
			active_o <= 1'b0;
		end else begin
			current_o <= current_d;
			active_o <= known_fn; // R02
		end
	end
endmodule : aod_scaler

// ===== rtl/aod_top.sv
`timescale 1ns/1ps
// Contract
// R01: wire-break enable bits 0..3, upper reserved
// R02: function FFh switches channel off
// R03: 31h maps 0..27648 to 0..20 mA
// R04: 41h maps 0..16384 to 0..20 mA
// R05: 30h maps 0..27648 to 4..20 mA
// R06: 40h maps 0..16384 to 4..20 mA
// R07: no interrupt; errors light led, recorded
// R08: parameter errors always, wire-break only enabled
// R09: record 01h full, 00h first four
// R10: summary byte error bit layout
// R11: module information class 0101b, bit4
// R12: internal byte overflow bit3, comm bit4
// R13: constant bits-per-channel and channel count bytes
// R14: channel group error bits 0..3
// R15: per-channel byte: bit0 param, bit4 wire
// R16: last four bytes hold event timestamp
// R17: free 32-bit microsecond timer, wraps
// R18: summary channel bit follows group byte
// R19: reserved bits read zero, ignore writes
module aod_top
	import aod_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// parameter record writes
	input wire logic prm_wr_i,
	input wire logic [7:0] prm_record_i,
	input wire logic [4:0] prm_index_i,
	input wire logic [7:0] prm_wdata_i,
	output logic prm_ack_o,
	output logic prm_err_o,
	// diagnostic record reads
	input wire logic diag_rd_i,
	input wire logic [7:0] diag_record_i,
	input wire logic [4:0] diag_index_i,
	output logic [7:0] diag_rdata_o,
	output logic diag_valid_o,
	output logic diag_err_o,
	// output codes, one per channel
	input wire logic [15:0] code0_i,
	input wire logic [15:0] code1_i,
	input wire logic [15:0] code2_i,
	input wire logic [15:0] code3_i,
	// status from the analog side
	input wire logic [3:0] open_load_i,
	input wire logic aux_supply_ok_i,
	input wire logic comm_error_i,
	// drive stage targets
	output logic [14:0] current0_o,
	output logic [14:0] current1_o,
	output logic [14:0] current2_o,
	output logic [14:0] current3_o,
	output logic [3:0] chan_active_o,
	// indicators
	output logic [3:0] chan_led_o,
	output logic group_led_o
);
	////////////////////////////////////////////////////////////////////////
	// parameter storage
	logic [3:0] wbe_q; // wire-break enables
	logic [7:0] fn_q [NUM_CH]; // function numbers
	logic prm_ack_q;
	logic prm_err_q;
	logic is_prm_base; // write targets the base record
	logic is_fn_rec; // write targets a function record
	logic [1:0] fn_ch; // channel addressed by the record
	logic prm_ok; // write accepted

	assign is_prm_base = (prm_record_i == REC_PRM_BASE) && (prm_index_i <= IDX_PRM_WIRE_BREAK);
	assign is_fn_rec = (prm_record_i[7:2] == REC_FN_CH0[7:2]) && (prm_index_i == 5'h00);
	assign fn_ch = prm_record_i[1:0];
	assign prm_ok = is_prm_base || is_fn_rec;

	// base record: byte 0 is reserved, writes to it are dropped
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wbe_q <= WIRE_BREAK_EN_RST[3:0];
		end else if (prm_wr_i && is_prm_base && (prm_index_i == IDX_PRM_WIRE_BREAK)) begin
			wbe_q <= prm_wdata_i[3:0] & WIRE_BREAK_EN_MASK; // R01 R19
		end
	end

	// function numbers; any byte is stored, bad ones flagged later
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				fn_q[i] <= FUNC_SEL_RST;
			end
		end else if (prm_wr_i && is_fn_rec) begin
			fn_q[fn_ch] <= prm_wdata_i;
		end
	end

	// write answer, one cycle after the strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prm_ack_q <= 1'b0;
			prm_err_q <= 1'b0;
		end else begin
			prm_ack_q <= prm_wr_i;
			prm_err_q <= prm_wr_i && !prm_ok;
		end
	end
	assign prm_ack_o = prm_ack_q;
	assign prm_err_o = prm_err_q;

	////////////////////////////////////////////////////////////////////////
	// channel scaling
	logic [15:0] codes [NUM_CH];
	logic [14:0] cur [NUM_CH];
	logic [3:0] active;

	assign codes[0] = code0_i;
	assign codes[1] = code1_i;
	assign codes[2] = code2_i;
	assign codes[3] = code3_i;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		aod_scaler u_scaler (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.func_i(fn_q[g]),
			.code_i(codes[g]),
			.current_o(cur[g]),
			.active_o(active[g])
		);
	end
	assign current0_o = cur[0];
	assign current1_o = cur[1];
	assign current2_o = cur[2];
	assign current3_o = cur[3];
	assign chan_active_o = active;

	////////////////////////////////////////////////////////////////////////
	// error detection
	logic [3:0] prm_bad; // function number not supported
	logic [3:0] wb_err; // reported wire breaks
	logic aux_missing;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_err
		// FFh is a legal choice, not a parameter fault
		assign prm_bad[g] = !((fn_q[g] == FN_OFF) || (fn_q[g] == FN_0_20_NOM27648)
			|| (fn_q[g] == FN_0_20_NOM16384) || (fn_q[g] == FN_4_20_NOM27648)
			|| (fn_q[g] == FN_4_20_NOM16384)); // R08
		// an off channel has no load to lose
		assign wb_err[g] = open_load_i[g] && wbe_q[g] && (fn_q[g] != FN_OFF) && !prm_bad[g]; // R08
	end
	assign aux_missing = !aux_supply_ok_i;

	////////////////////////////////////////////////////////////////////////
	// microsecond timer
	logic [7:0] div_q; // cycles within one microsecond
	logic [31:0] us_q; // free-running ticker
	logic tick;

	assign tick = (div_q == 8'(TICK_CYCLES - 1));

	// divider and ticker; natural wrap after all ones
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_q <= 8'h00;
			us_q <= 32'h0000_0000; // R17
		end else begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			if (tick) begin
				us_q <= us_q + 32'h0000_0001; // R17
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// diagnostic events and timestamp
	logic [9:0] evt_vec; // every error source in one word
	logic [9:0] evt_prev_q;
	logic new_evt; // some source went from clear to set
	logic pend_q; // event not yet read out
	logic ovf_q; // event arrived while one was pending
	logic [31:0] stamp_q;
	logic ack_rd; // read of byte 0 acknowledges the event

	assign evt_vec = {comm_error_i, aux_missing, wb_err, prm_bad};
	assign new_evt = |(evt_vec & ~evt_prev_q);
	assign ack_rd = diag_rd_i && (diag_index_i == 5'h00)
		&& ((diag_record_i == REC_DIAG_FULL) || (diag_record_i == REC_DIAG_SHORT));

	// event capture; a new event beats a clearing read
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_prev_q <= 10'h000;
			pend_q <= 1'b0;
			ovf_q <= 1'b0;
			stamp_q <= 32'h0000_0000;
		end else begin
			evt_prev_q <= evt_vec;
			if (new_evt) begin
				stamp_q <= us_q; // R16
				pend_q <= 1'b1;
				ovf_q <= pend_q || (ovf_q && !ack_rd); // R12
			end else if (ack_rd) begin
				pend_q <= 1'b0;
				ovf_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// diagnostic record assembly
	logic [7:0] ch_byte [NUM_CH]; // per-channel error bytes
	logic [3:0] grp_err;
	logic [7:0] int_byte;
	logic [7:0] sum_byte;
	logic [7:0] modinfo_byte;
	logic [7:0] rec_bytes [DIAG_FULL_LEN];
	logic int_err;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_chb
		assign ch_byte[g] = {3'b000, wb_err[g], 3'b000, prm_bad[g]}; // R15 R19
		assign grp_err[g] = |ch_byte[g]; // R14
	end
	assign int_byte = {3'b000, comm_error_i, ovf_q, 3'b000}; // R12 R19
	assign int_err = |int_byte;
	// module failure: no drive possible without the auxiliary supply
	assign sum_byte = {|prm_bad, 2'b00, aux_missing, |grp_err, |wb_err, int_err,
		aux_missing | int_err}; // R10 R18
	assign modinfo_byte = {3'b000, MODULE_INFO_RST[MODINFO_CHAN_PRESENT], MODULE_INFO_RST[3:0]}; // R11

	assign rec_bytes[0] = sum_byte;
	assign rec_bytes[1] = modinfo_byte;
	assign rec_bytes[2] = 8'h00; // R19
	assign rec_bytes[3] = int_byte;
	assign rec_bytes[4] = CHANNEL_KIND_RST;
	assign rec_bytes[5] = DIAG_BITS_BYTE; // R13
	assign rec_bytes[6] = NUM_CH_BYTE; // R13
	assign rec_bytes[7] = {4'h0, grp_err}; // R14
	assign rec_bytes[8] = ch_byte[0];
	assign rec_bytes[9] = ch_byte[1];
	assign rec_bytes[10] = ch_byte[2];
	assign rec_bytes[11] = ch_byte[3];
	assign rec_bytes[12] = 8'h00; // R19
	assign rec_bytes[13] = 8'h00;
	assign rec_bytes[14] = 8'h00;
	assign rec_bytes[15] = 8'h00;
	assign rec_bytes[16] = stamp_q[7:0]; // R16
	assign rec_bytes[17] = stamp_q[15:8];
	assign rec_bytes[18] = stamp_q[23:16];
	assign rec_bytes[19] = stamp_q[31:24];

	////////////////////////////////////////////////////////////////////////
	// diagnostic read port
	logic rd_full; // index inside the full record
	logic rd_short; // index inside the short record
	logic rd_ok;
	logic [7:0] rd_byte;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic rerr_q;

	assign rd_full = (diag_record_i == REC_DIAG_FULL) && (diag_index_i < 5'(DIAG_FULL_LEN)); // R09
	assign rd_short = (diag_record_i == REC_DIAG_SHORT)
		&& (diag_index_i < 5'(DIAG_SHORT_LEN)); // R09
	assign rd_ok = rd_full || rd_short;
	assign rd_byte = rd_ok ? rec_bytes[diag_index_i] : 8'h00;

	// one-cycle read answer; refused reads return zero and an error
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			rerr_q <= 1'b0;
		end else begin
			rvalid_q <= diag_rd_i;
			rerr_q <= diag_rd_i && !rd_ok;
			if (diag_rd_i) begin
				rdata_q <= rd_byte;
			end
		end
	end
	assign diag_rdata_o = rdata_q;
	assign diag_valid_o = rvalid_q;
	assign diag_err_o = rerr_q;

	////////////////////////////////////////////////////////////////////////
	// indicators; status only, no interrupt line exists
	logic [3:0] led_q;
	logic grp_led_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			led_q <= 4'h0;
			grp_led_q <= 1'b0;
		end else begin
			led_q <= grp_err; // R07
			grp_led_q <= |sum_byte; // R07
		end
	end
	assign chan_led_o = led_q;
	assign group_led_o = grp_led_q;
endmodule : aod_top

// ===== testbench/aod_props.sv
`timescale 1ns/1ps
module aod_props
	import aod_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic prm_wr_i,
	input wire logic prm_ack_o,
	input wire logic prm_err_o,
	input wire logic diag_rd_i,
	input wire logic [7:0] diag_record_i,
	input wire logic [4:0] diag_index_i,
	input wire logic [7:0] diag_rdata_o,
	input wire logic diag_valid_o,
	input wire logic diag_err_o,
	input wire logic [14:0] current0_o,
	input wire logic [3:0] chan_active_o,
	input wire logic [3:0] chan_led_o,
	input wire logic group_led_o
);
	// record decode shared by all byte checks
	wire rf = diag_rd_i && diag_record_i == REC_DIAG_FULL;
	wire rs = diag_rd_i && diag_record_i == REC_DIAG_SHORT;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	a_prm_ack: assert property (prm_ack_o == $past(prm_wr_i)) else $error("ack");
	a_err_pair: assert property (prm_err_o |-> prm_ack_o) else $error("lone err");
	a_rd_valid: assert property (diag_valid_o == $past(diag_rd_i)) else $error("valid");
	a_rd_range: assert property (rf && diag_index_i > 5'd19 || rs && diag_index_i > 5'd3
		|=> diag_err_o && diag_rdata_o == 8'h00) else $error("range");
	a_rd_rec: assert property (diag_rd_i && !rf && !rs |=> diag_err_o) else $error("rec");
	a_mod_info: assert property (rf && diag_index_i == 5'd1 |=> diag_rdata_o == 8'h15)
		else $error("modinfo");
	a_const_cnt: assert property (rf && diag_index_i inside {5'd5, 5'd6}
		|=> diag_rdata_o == ($past(diag_index_i) == 5'd5 ? 8'h08 : 8'h04)) else $error("cnt");
	a_rsvd_zero: assert property (rf && diag_index_i inside {5'd2, [5'd12:5'd15]}
		|=> diag_rdata_o == 8'h00) else $error("rsvd");
	a_grp_bits: assert property (rf && diag_index_i == 5'd7 |=> diag_rdata_o[7:4] == 4'h0)
		else $error("grp");
	a_chan_bits: assert property (rf && diag_index_i inside {[5'd8:5'd11]}
		|=> (diag_rdata_o & 8'hee) == 8'h00) else $error("chan");
	// read data may only move with its valid pulse
	a_data_hold: assert property ($changed(diag_rdata_o) |-> diag_valid_o) else $error("hold");
	a_led_group: assert property (|chan_led_o |-> group_led_o) else $error("led");
	a_off_zero: assert property (!chan_active_o[0] |-> current0_o == 15'h0000)
		else $error("off");
	c_prm_err: cover property (prm_err_o);
	c_diag_err: cover property (diag_err_o);
	c_led: cover property (|chan_led_o);
endmodule : aod_props

bind aod_top aod_props u_props (.clk_i, .rst_i, .prm_wr_i, .prm_ack_o, .prm_err_o, .diag_rd_i,
	.diag_record_i, .diag_index_i, .diag_rdata_o, .diag_valid_o, .diag_err_o, .current0_o,
	.chan_active_o, .chan_led_o, .group_led_o);

// ===== testbench/aod_host.sv
`timescale 1ns/1ps
module aod_host
	import aod_pkg::*;
(
	input wire logic clk_i,
	input wire logic prm_ack_i,
	input wire logic prm_err_i,
	input wire logic [7:0] diag_rdata_i,
	input wire logic diag_valid_i,
	input wire logic diag_err_i,
	output logic prm_wr_o,
	output logic [7:0] prm_record_o,
	output logic [4:0] prm_index_o,
	output logic [7:0] prm_wdata_o,
	output logic diag_rd_o,
	output logic [7:0] diag_record_o,
	output logic [4:0] diag_index_o
);
	initial begin
		prm_wr_o = 1'b0;
		prm_record_o = 8'h00;
		prm_index_o = 5'h00;
		prm_wdata_o = 8'h00;
		diag_rd_o = 1'b0;
		diag_record_o = 8'h00;
		diag_index_o = 5'h00;
	end
	////////////////////////////////////////////////////////////////
	// one byte per strobe; a missing answer comes back as unknown
	task wr(input logic [7:0] r, input logic [4:0] i, input logic [7:0] d, output logic e);
		@(posedge clk_i);
		prm_record_o <= r;
		prm_index_o <= i;
		prm_wdata_o <= d;
		prm_wr_o <= 1'b1;
		@(posedge clk_i);
		prm_wr_o <= 1'b0;
		prm_wdata_o <= ~d; // released bus does not keep the byte
		@(posedge clk_i);
		e = prm_ack_i ? prm_err_i : 1'bx;
	endtask : wr
	// record 01h full, 00h first four bytes
	task rd(input logic [7:0] r, input logic [4:0] i, output logic [7:0] d, output logic e);
		@(posedge clk_i);
		diag_record_o <= r;
		diag_index_o <= i;
		diag_rd_o <= 1'b1;
		@(posedge clk_i);
		diag_rd_o <= 1'b0;
		diag_index_o <= ~i;
		@(posedge clk_i);
		d = diag_rdata_i;
		e = diag_valid_i ? diag_err_i : 1'bx;
	endtask : rd
endmodule : aod_host

// ===== testbench/analog_out_channel_diag_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("Error %0t: %h vs %h", $time, (a), (b)); end end
module analog_out_channel_diag_bench
	import aod_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] code[4] = '{default: 16'h0000};
	logic [3:0] open_load_i = 4'h0;
	logic aux_supply_ok_i = 1'b1;
	logic comm_error_i = 1'b0;
	wire prm_wr_i, prm_ack_o, prm_err_o, diag_rd_i, diag_valid_o, diag_err_o, group_led_o;
	wire [7:0] prm_record_i, prm_wdata_i, diag_record_i, diag_rdata_o;
	wire [4:0] prm_index_i, diag_index_i;
	wire [14:0] current0_o, current1_o, current2_o, current3_o;
	wire [3:0] chan_active_o, chan_led_o;
	wire [14:0] cur[4];
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	logic [7:0] d;
	logic e;
	logic [31:0] s1, s2;
	// scaling cases, channel is row mod 4; rows 8..11 leave the final setup
	logic [7:0] tf[12] = '{8'h31, 8'h31, 8'h31, 8'h41, 8'h41, 8'h30, 8'h30, 8'h30,
		8'h40, 8'hff, 8'h55, 8'h40};
	logic [15:0] tc[12] = '{16'h6c00, 16'hffff, 16'h7fff, 16'h4000, 16'h7530, 16'h0000,
		16'h7eff, 16'hec00, 16'hf000, 16'h4000, 16'h4000, 16'h5000};
	// targets in uA worked out by hand from the fixed-point scale factors, one per row
	logic [14:0] te[12] = '{15'h4e1f, 15'h0000, 15'h5bdd, 15'h4e20, 15'h61a8, 15'h0fa0,
		15'h591e, 15'h040d, 15'h0000, 15'h0000, 15'h0000, 15'h5dc0};
	logic [7:0] img[20] = '{1: 8'h15, 4: 8'h73, 5: 8'h08, 6: 8'h04, default: 8'h00};
	assign cur[0] = current0_o;
	assign cur[1] = current1_o;
	assign cur[2] = current2_o;
	assign cur[3] = current3_o;
	aod_top dut (.clk_i, .rst_i, .prm_wr_i, .prm_record_i, .prm_index_i, .prm_wdata_i,
		.prm_ack_o, .prm_err_o, .diag_rd_i, .diag_record_i, .diag_index_i, .diag_rdata_o,
		.diag_valid_o, .diag_err_o, .code0_i(code[0]), .code1_i(code[1]), .code2_i(code[2]),
		.code3_i(code[3]), .open_load_i, .aux_supply_ok_i, .comm_error_i, .current0_o,
		.current1_o, .current2_o, .current3_o, .chan_active_o, .chan_led_o, .group_led_o);
	aod_host host (.clk_i, .prm_ack_i(prm_ack_o), .prm_err_i(prm_err_o),
		.diag_rdata_i(diag_rdata_o), .diag_valid_i(diag_valid_o), .diag_err_i(diag_err_o),
		.prm_wr_o(prm_wr_i), .prm_record_o(prm_record_i), .prm_index_o(prm_index_i),
		.prm_wdata_o(prm_wdata_i), .diag_rd_o(diag_rd_i), .diag_record_o(diag_record_i),
		.diag_index_o(diag_index_i));
	////////////////////////////////////////////////////////////////
	always #2 clk_i = ~clk_i;
	// hang guard, well above the few thousand cycles needed
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			bad_count++;
			end_sim();
		end
	end
	// target in microamps, floor of the scaled code plus offset
	function automatic logic [14:0] exp_ua(input logic [7:0] f, input logic signed [15:0] c);
		longint k, lo, hi, o, v;
		lo = 0;
		o = 0;
		hi = CODE_MAX_27648;
		case (f)
			FN_0_20_NOM27648: k = K_20MA_27648;
			FN_0_20_NOM16384: begin
				k = K_20MA_16384;
				hi = CODE_MAX_16384;
			end
			FN_4_20_NOM27648: begin
				k = K_16MA_27648;
				lo = CODE_MIN_4MA_27648;
				o = OFFSET_4MA_UA;
			end
			FN_4_20_NOM16384: begin
				k = K_16MA_16384;
				lo = CODE_MIN_4MA_16384;
				hi = CODE_MAX_16384;
				o = OFFSET_4MA_UA;
			end
			default: return 15'h0000; // off or unknown drives nothing
		endcase
		v = (c < lo) ? lo : ((c > hi) ? hi : c);
		v = ((v * k) >>> 16) + o;
		// nothing below 0 mA can be driven
		return (v < 0) ? 15'h0000 : 15'(v);
	endfunction : exp_ua
	task rc(input logic [7:0] r, input logic [4:0] i, input logic [7:0] x, input logic ex);
		host.rd(r, i, d, e);
		`CHK(d, x)
		`CHK(e, ex)
	endtask : rc
	task fn(input int ch, input logic [7:0] f);
		host.wr(8'(REC_FN_CH0 + ch), 5'h00, f, e);
		`CHK(e, 1'b0)
	endtask : fn
	task rs(output logic [31:0] v);
		for (int b = 0; b < 4; b++) begin
			host.rd(REC_DIAG_FULL, 5'(16 + b), d, e);
			v[8 * b +: 8] = d;
		end
	endtask : rs
	task end_sim;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 20; i++) rc(REC_DIAG_FULL, 5'(i), img[i], 1'b0);
		rc(REC_DIAG_SHORT, 5'h01, 8'h15, 1'b0);
		rc(REC_DIAG_SHORT, 5'h04, 8'h00, 1'b1);
		rc(REC_DIAG_FULL, 5'h14, 8'h00, 1'b1);
		rc(8'h02, 5'h00, 8'h00, 1'b1);
		host.wr(8'h84, 5'h00, 8'h31, e);
		`CHK(e, 1'b1)
		host.wr(REC_PRM_BASE, 5'h00, 8'hff, e);
		`CHK(e, 1'b0)
		// every format, the 31h and 41h clamps, the unknown code and the off code
		for (int i = 0; i < 12; i++) begin
			fn(i % 4, tf[i]);
			code[i % 4] <= tc[i];
			repeat (3) @(posedge clk_i);
			`CHK(cur[i % 4], exp_ua(tf[i], tc[i]))
			`CHK(cur[i % 4], te[i])
			`CHK(chan_active_o[i % 4], (tf[i] inside {8'h30, 8'h31, 8'h40, 8'h41}))
		end
		// channel 2 holds an invalid function number
		rc(REC_DIAG_FULL, 5'h0a, 8'h01, 1'b0);
		rc(REC_DIAG_FULL, 5'h07, 8'h04, 1'b0);
		`CHK(({chan_led_o, group_led_o}), 5'b01001)
		rc(REC_DIAG_FULL, 5'h00, 8'h88, 1'b0);
		fn(2, FN_0_20_NOM27648);
		open_load_i <= 4'h3;
		// enable only the switched-off channel: no wire break may show
		host.wr(REC_PRM_BASE, IDX_PRM_WIRE_BREAK, 8'hf2, e);
		`CHK(e, 1'b0)
		repeat (3) @(posedge clk_i);
		rc(REC_DIAG_FULL, 5'h07, 8'h00, 1'b0);
		host.wr(REC_PRM_BASE, IDX_PRM_WIRE_BREAK, 8'hf1, e);
		`CHK(e, 1'b0)
		repeat (3) @(posedge clk_i);
		rc(REC_DIAG_FULL, 5'h08, 8'h10, 1'b0);
		rs(s1);
		repeat (2500) @(posedge clk_i);
		comm_error_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rs(s2);
		`CHK(((s2 - s1) inside {32'd10, 32'd11}), 1'b1)
		rc(REC_DIAG_FULL, 5'h03, 8'h18, 1'b0);
		rc(REC_DIAG_FULL, 5'h00, 8'h0f, 1'b0);
		comm_error_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rc(REC_DIAG_FULL, 5'h03, 8'h00, 1'b0);
		aux_supply_ok_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rc(REC_DIAG_SHORT, 5'h00, 8'h1d, 1'b0);
		// switch channel 0 off, then give it a live code: target must stay at zero
		fn(0, FN_OFF);
		code[0] <= 16'h4000;
		repeat (3) @(posedge clk_i);
		`CHK(cur[0], 15'h0000)
		`CHK(chan_active_o[0], 1'b0)
		end_sim();
	end
endmodule : analog_out_channel_diag_bench
